// >>> design/card_supply_timer_and_detect.sv
// Card slot supervision: supply activation timer, off delay and presence detect
// Function
// - Non-zero supply select write starts supply-stable timer; supply good checked at expiry.
// - Supply good false at expiry: card event interrupt, deactivation, select cleared.
// - Activation continues only with supply good true, else hardware clears select.
// - Stable interval is low timing nibble times one 32768 Hz period.
// - Select written to zero while active delays deactivation by high nibble 32768 Hz periods; during the stable wait it deactivates at once.
// - Off-delay of zero adds no delay; non-zero adds that many periods.
// - Supply fault or card event deactivations skip the off-delay.
// - With debounce on, inserted flag sets after 64 ms stable detect, 1 kHz.
// - Inserted flag clears at once when detect de-asserts.
// - Detection active only with detect enable set; enable resets to zero.
// - Polarity one: high pin means present; zero: low pin means present.
// - Active-low pull-up and active-high pull-down enables from control bits.
// - Any change of read-only inserted flag is a card event; read is polarity-adjusted.
// - Presence detection keeps working while card logic clock is stopped.
// - Power-down bit set bypasses debounce; presence still reported from pin.
// - Select 00 off, 01 1.8 V, 10 3.0 V, 11 5 V; non-zero activates.
// - Card event or falling supply good deactivates; supply off after lines idle.
`timescale 1ns/1ps
module card_supply_timer_and_detect (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Timing ticks
  input  wire logic        tick_32k_i,
  input  wire logic        tick_1k_i,
  // Supply circuit
  input  wire logic        supply_good_i,
  input  wire logic        lines_idle_i,
  output logic      [1:0]  supply_select_o,
  output logic             deact_req_o,
  output logic             card_logic_powerdown_o,
  // Detect pin
  input  wire logic        presence_pin_i,
  output logic             pullup_enable_n_o,
  output logic             pulldown_enable_o,
  output logic             card_inserted_o,
  // Interrupt
  output logic             irq_o
);

  // ==========================================================
  // Register storage
  logic [7:0]                  timing_r;
  logic [7:0]                  detect_ctl_r;
  logic [1:0]                  supply_select_r;
  logic                        powerdown_r;
  logic [card_supply_pkg::IRQ_W-1:0] irq_status_r;
  logic [card_supply_pkg::IRQ_W-1:0] irq_mask_r;
  logic [7:0]                  rdata_r;
  logic                        irq_r;

  logic wr_timing;
  logic wr_detect;
  logic wr_supply;
  logic wr_status;
  logic wr_mask;

  assign wr_timing = wr_i && (addr_i == card_supply_pkg::ADDR_SUPPLY_TIMING);
  assign wr_detect = wr_i && (addr_i == card_supply_pkg::ADDR_DETECT_CONTROL);
  assign wr_supply = wr_i && (addr_i == card_supply_pkg::ADDR_SUPPLY_CONTROL);
  assign wr_status = wr_i && (addr_i == card_supply_pkg::ADDR_IRQ_STATUS);
  assign wr_mask   = wr_i && (addr_i == card_supply_pkg::ADDR_IRQ_MASK);

  // Field views
  logic [3:0] stable_field;
  logic [3:0] offdly_field;
  logic [1:0] sel_wdata;
  logic       det_en;
  logic       polarity;
  logic       debounce_en;

  assign stable_field = timing_r[card_supply_pkg::STABLE_LSB +: card_supply_pkg::NIBBLE_W];
  assign offdly_field = timing_r[card_supply_pkg::OFFDLY_LSB +: card_supply_pkg::NIBBLE_W];
  assign sel_wdata    = wdata_i[card_supply_pkg::SEL_LSB +: card_supply_pkg::SEL_W];
  assign det_en       = detect_ctl_r[card_supply_pkg::BIT_DET_EN];
  assign polarity     = detect_ctl_r[card_supply_pkg::BIT_POLARITY];
  assign debounce_en  = detect_ctl_r[card_supply_pkg::BIT_DEBOUNCE];

  // Timing register
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timing_r <= card_supply_pkg::RST_SUPPLY_TIMING;
    else if (wr_timing)
      timing_r <= wdata_i;
  end

  // Detect control; inserted bit is read-only and lives elsewhere
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      detect_ctl_r <= card_supply_pkg::RST_DETECT_CONTROL;
    else if (wr_detect)
      detect_ctl_r <= wdata_i & card_supply_pkg::DETECT_WR_MASK;
  end

  // Pin control outputs follow their control bits
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pullup_enable_n_o <= 1'b1;
      pulldown_enable_o <= 1'b0;
    end
    else
    begin
      pullup_enable_n_o <= detect_ctl_r[card_supply_pkg::BIT_PULLUP_N];
      pulldown_enable_o <= detect_ctl_r[card_supply_pkg::BIT_PULLDOWN];
    end
  end

  // ==========================================================
  // Presence detection
  logic present_raw;
  logic deb_zero;
  logic inserted_r;
  logic inserted_nxt;
  logic inserted_d_r;
  logic card_event;

  // Polarity adjusted presence, gated by enable
  assign present_raw = det_en && (polarity ? presence_pin_i : !presence_pin_i);

  // Debounce counter reloads while the card looks absent
  tick_down_counter #(
    .W (card_supply_pkg::DEBOUNCE_W)
  ) u_debounce (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .load_i     (!present_raw),
    .load_val_i (card_supply_pkg::DEBOUNCE_W'(card_supply_pkg::DEBOUNCE_TICKS)),
    .tick_i     (tick_1k_i),
    .zero_o     (deb_zero)
  );

  // Flag rule: drop at once, rise after debounce unless bypassed
  always_comb
  begin
    if (!present_raw)
      inserted_nxt = 1'b0;
    else if (debounce_en && !powerdown_r)
      inserted_nxt = inserted_r || deb_zero;
    else
      inserted_nxt = 1'b1;
  end

  // Runs on the always-on clock, independent of card logic clock
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      inserted_r   <= 1'b0;
      inserted_d_r <= 1'b0;
    end
    else
    begin
      inserted_r   <= inserted_nxt;
      inserted_d_r <= inserted_r;
    end
  end

  assign card_event = inserted_r ^ inserted_d_r;
  assign card_inserted_o = inserted_r;

  // ==========================================================
  // Supply sequencer
  card_supply_pkg::supply_state_t state_r;
  card_supply_pkg::supply_state_t state_nxt;
  logic tmr_load;
  logic [3:0] tmr_val;
  logic tmr_zero;
  logic start_act;
  logic stop_req;
  logic supply_good_d_r;
  logic supply_fall;
  logic supply_fail;
  logic deact_done;

  assign start_act   = wr_supply && (sel_wdata != card_supply_pkg::SEL_OFF);
  assign stop_req    = wr_supply && (sel_wdata == card_supply_pkg::SEL_OFF);
  assign supply_fall = supply_good_d_r && !supply_good_i;

  // Shared timer: stable interval or off delay
  tick_down_counter #(
    .W (card_supply_pkg::NIBBLE_W)
  ) u_supply_timer (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .tick_i     (tick_32k_i),
    .zero_o     (tmr_zero)
  );

  // Next state and timer reload
  always_comb
  begin
    state_nxt   = state_r;
    tmr_load    = 1'b0;
    tmr_val     = stable_field;
    supply_fail = 1'b0;
    deact_done  = 1'b0;
    case (state_r)
      card_supply_pkg::SUP_IDLE:
      begin
        if (start_act)
        begin
          tmr_load  = 1'b1;
          state_nxt = card_supply_pkg::SUP_WAIT_STABLE;
        end
      end
      card_supply_pkg::SUP_WAIT_STABLE:
      begin
        if (card_event || stop_req)
          state_nxt = card_supply_pkg::SUP_DEACT;
        else if (tmr_zero)
        begin
          if (supply_good_i)
            state_nxt = card_supply_pkg::SUP_ACTIVE;
          else
          begin
            supply_fail = 1'b1;
            state_nxt   = card_supply_pkg::SUP_DEACT;
          end
        end
      end
      card_supply_pkg::SUP_ACTIVE:
      begin
        if (card_event || supply_fall)
          state_nxt = card_supply_pkg::SUP_DEACT;
        else if (stop_req)
        begin
          tmr_load  = 1'b1;
          tmr_val   = offdly_field;
          state_nxt = card_supply_pkg::SUP_OFF_DELAY;
        end
      end
      card_supply_pkg::SUP_OFF_DELAY:
      begin
        if (card_event || supply_fall || tmr_zero)
          state_nxt = card_supply_pkg::SUP_DEACT;
      end
      card_supply_pkg::SUP_DEACT:
      begin
        if (lines_idle_i)
        begin
          deact_done = 1'b1;
          state_nxt  = card_supply_pkg::SUP_IDLE;
        end
      end
      default:
        state_nxt = card_supply_pkg::SUP_IDLE;
    endcase
  end

  // State and supply good history
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r         <= card_supply_pkg::SUP_IDLE;
      supply_good_d_r <= 1'b0;
    end
    else
    begin
      state_r         <= state_nxt;
      supply_good_d_r <= supply_good_i;
    end
  end

  // Select bits: hardware clears on any entry to deactivation; software writes take effect only in idle, or a zero write while active
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      supply_select_r <= card_supply_pkg::SEL_OFF;
    else if (state_r != card_supply_pkg::SUP_ACTIVE && state_r != card_supply_pkg::SUP_WAIT_STABLE
             && state_nxt == card_supply_pkg::SUP_DEACT)
      supply_select_r <= card_supply_pkg::SEL_OFF;
    else if ((state_r == card_supply_pkg::SUP_WAIT_STABLE || state_r == card_supply_pkg::SUP_ACTIVE)
             && state_nxt == card_supply_pkg::SUP_DEACT)
      supply_select_r <= card_supply_pkg::SEL_OFF;
    else if (wr_supply && state_r == card_supply_pkg::SUP_IDLE)
      supply_select_r <= sel_wdata;
    else if (stop_req && state_r == card_supply_pkg::SUP_ACTIVE)
      supply_select_r <= card_supply_pkg::SEL_OFF;
  end

  // Power-down bit
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      powerdown_r <= 1'b0;
    else if (wr_supply)
      powerdown_r <= wdata_i[card_supply_pkg::BIT_CARD_LOGIC_POWERDOWN];
  end

  // Supply stays on until the lines are idle
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      supply_select_o        <= card_supply_pkg::SEL_OFF;
      deact_req_o            <= 1'b0;
      card_logic_powerdown_o <= 1'b0;
    end
    else
    begin
      deact_req_o            <= (state_nxt == card_supply_pkg::SUP_DEACT);
      card_logic_powerdown_o <= powerdown_r;
      if (state_nxt == card_supply_pkg::SUP_IDLE)
        supply_select_o <= card_supply_pkg::SEL_OFF;
      else if (state_r == card_supply_pkg::SUP_IDLE)
        supply_select_o <= sel_wdata;
    end
  end

  // ==========================================================
  // Interrupts: sticky status, set wins over write-one clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_status_r <= '0;
    else
    begin
      if (card_event || supply_fail)
        irq_status_r[card_supply_pkg::IRQ_CARD_EVENT] <= 1'b1;
      else if (wr_status && wdata_i[card_supply_pkg::IRQ_CARD_EVENT])
        irq_status_r[card_supply_pkg::IRQ_CARD_EVENT] <= 1'b0;
      if (deact_done)
        irq_status_r[card_supply_pkg::IRQ_DEACT_DONE] <= 1'b1;
      else if (wr_status && wdata_i[card_supply_pkg::IRQ_DEACT_DONE])
        irq_status_r[card_supply_pkg::IRQ_DEACT_DONE] <= 1'b0;
    end
  end

  // Mask register and interrupt line
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_mask_r <= card_supply_pkg::RST_IRQ_MASK[card_supply_pkg::IRQ_W-1:0];
      irq_r      <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        irq_mask_r <= wdata_i[card_supply_pkg::IRQ_W-1:0];
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  assign irq_o = irq_r;

  // ==========================================================
  // Read port: data valid only the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_r <= 8'h00;
    else if (!rd_i)
      rdata_r <= 8'h00;
    else
    begin
      case (addr_i)
        card_supply_pkg::ADDR_SUPPLY_TIMING:  rdata_r <= timing_r;
        card_supply_pkg::ADDR_DETECT_CONTROL: rdata_r <= detect_ctl_r | {7'h00, inserted_r};
        card_supply_pkg::ADDR_SUPPLY_CONTROL:
          rdata_r <= {supply_select_r, 2'h0, supply_good_i, 2'h0, powerdown_r};
        card_supply_pkg::ADDR_IRQ_STATUS:     rdata_r <= {6'h00, irq_status_r};
        card_supply_pkg::ADDR_IRQ_MASK:       rdata_r <= {6'h00, irq_mask_r};
        default:                              rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_fail_clears_sel: assert property (
    supply_fail |=> (supply_select_r == card_supply_pkg::SEL_OFF)
      && irq_status_r[card_supply_pkg::IRQ_CARD_EVENT] && deact_req_o)
    else $error("Supply fail did not clear select and raise event");
  chk_good_continues: assert property (
    (state_r == card_supply_pkg::SUP_WAIT_STABLE) && tmr_zero && supply_good_i && !card_event
      && !stop_req |=> state_r == card_supply_pkg::SUP_ACTIVE)
    else $error("Good supply did not continue activation");
  chk_start_timer: assert property (
    (state_r == card_supply_pkg::SUP_IDLE) && start_act |=> state_r == card_supply_pkg::SUP_WAIT_STABLE)
    else $error("Activation did not start the stable timer");
  chk_remove_fast: assert property (
    !present_raw |=> !card_inserted_o)
    else $error("Inserted flag not cleared at once");
  chk_disabled_off: assert property (
    !det_en |=> !card_inserted_o)
    else $error("Flag set while detection disabled");
  chk_no_debounce: assert property (
    present_raw && (!debounce_en || powerdown_r) |=> card_inserted_o)
    else $error("Presence not reported without debounce");
  chk_debounce_hold: assert property (
    $rose(present_raw) && debounce_en && !powerdown_r |=> !card_inserted_o)
    else $error("Debounce bypassed");
  chk_event_irq: assert property (
    card_event |=> irq_status_r[card_supply_pkg::IRQ_CARD_EVENT])
    else $error("Card event not recorded");
  chk_emerg_skip: assert property (
    (state_r == card_supply_pkg::SUP_OFF_DELAY) && (card_event || supply_fall) |=> deact_req_o)
    else $error("Emergency deactivation waited for off delay");
  chk_supply_held: assert property (
    deact_req_o && !lines_idle_i && (supply_select_o != card_supply_pkg::SEL_OFF)
      |=> supply_select_o != card_supply_pkg::SEL_OFF)
    else $error("Supply dropped before lines idle");
  chk_pull_pins: assert property (
    $past(arst_n_i) |->
      pullup_enable_n_o == $past(detect_ctl_r[card_supply_pkg::BIT_PULLUP_N])
      && pulldown_enable_o == $past(detect_ctl_r[card_supply_pkg::BIT_PULLDOWN]))
    else $error("Pull enables do not follow control");

  cov_activation: cover property (state_r == card_supply_pkg::SUP_WAIT_STABLE ##[1:300]
    state_r == card_supply_pkg::SUP_ACTIVE);
  cov_supply_fail: cover property (supply_fail);
  cov_off_delay: cover property (state_r == card_supply_pkg::SUP_OFF_DELAY ##1
    state_r == card_supply_pkg::SUP_DEACT);
  cov_insert: cover property ($rose(card_inserted_o));

endmodule

// >>> design/card_supply_pkg.sv
// Constants for the card supply timer and presence detector
package card_supply_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] ADDR_SUPPLY_TIMING  = 16'hFE04;
  localparam logic [15:0] ADDR_DETECT_CONTROL = 16'hFE05;
  localparam logic [15:0] ADDR_SUPPLY_CONTROL = 16'hFE10;
  localparam logic [15:0] ADDR_IRQ_STATUS     = 16'hFE11;
  localparam logic [15:0] ADDR_IRQ_MASK       = 16'hFE12;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_SUPPLY_TIMING  = 8'h0F;
  localparam logic [7:0] RST_DETECT_CONTROL = 8'h00;
  localparam logic [7:0] RST_SUPPLY_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK       = 8'h00;

  // ==========================================================
  // Supply timing fields
  localparam int STABLE_LSB = 0;
  localparam int OFFDLY_LSB = 4;
  localparam int NIBBLE_W   = 4;

  // Detect control fields
  localparam int BIT_DEBOUNCE = 7;
  localparam int BIT_DET_EN   = 6;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_PULLUP_N = 2;
  localparam int BIT_PULLDOWN = 1;
  localparam int BIT_INSERTED = 0;
  localparam logic [7:0] DETECT_WR_MASK = 8'hCE;

  // Supply control fields
  localparam int SEL_LSB      = 6;
  localparam int SEL_W        = 2;
  localparam int BIT_SUP_GOOD = 3;
  localparam int BIT_CARD_LOGIC_POWERDOWN    = 0;
  localparam logic [1:0] SEL_OFF = 2'h0;

  // Interrupt status bits
  localparam int IRQ_CARD_EVENT = 0;
  localparam int IRQ_DEACT_DONE = 1;
  localparam int IRQ_W          = 2;

  // ==========================================================
  // Debounce timing
  localparam int DEBOUNCE_MS     = 64;
  localparam int TICK_1K_MS      = 1;
  localparam int DEBOUNCE_TICKS  = DEBOUNCE_MS / TICK_1K_MS;
  localparam int DEBOUNCE_W      = 7;

  // Supply sequencer states
  typedef enum logic [2:0] {
    SUP_IDLE,
    SUP_WAIT_STABLE,
    SUP_ACTIVE,
    SUP_OFF_DELAY,
    SUP_DEACT
  } supply_state_t;

endpackage

// >>> design/tick_down_counter.sv
// Loadable down counter that steps on a tick pulse and stops at zero
`timescale 1ns/1ps
module tick_down_counter #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         tick_i,
  // Status
  output logic              zero_o
);

  logic [W-1:0] count_r;

  // Reload wins over a tick; hold at zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_r <= '0;
    end
    else if (load_i)
    begin
      count_r <= load_val_i;
    end
    else if (tick_i && (count_r != '0))
    begin
      count_r <= count_r - W'(1);
    end
  end

  assign zero_o = (count_r == '0);

endmodule

// >>> verif/card_far_side.sv
// Far-side model: card detect switch and card supply circuit
`timescale 1ns/1ps
module card_far_side (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  // Supply command from the block
  input  wire logic [1:0] supply_select_i,
  input  wire logic       deact_req_i,
  // Scenario controls
  input  wire logic       fail_i,
  input  wire logic       card_in_i,
  input  wire logic       pin_high_i,
  // Far-side lines
  output logic            supply_good_o,
  output logic            lines_idle_o,
  output logic            presence_pin_o
);
  logic [2:0] ramp_r;
  logic [1:0] idle_cnt_r;

  // Supply ramps for five cycles; a fault holds it low
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ramp_r <= 3'h0;
    else if (supply_select_i == 2'h0 || fail_i)
      ramp_r <= 3'h0;
    else if (ramp_r != 3'h5)
      ramp_r <= ramp_r + 3'h1;
  end
  assign supply_good_o = (ramp_r == 3'h5) && !fail_i;

  // Card lines settle three cycles after a deactivation request
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      idle_cnt_r <= 2'h0;
    else if (!deact_req_i)
      idle_cnt_r <= 2'h0;
    else if (idle_cnt_r != 2'h3)
      idle_cnt_r <= idle_cnt_r + 2'h1;
  end
  assign lines_idle_o = deact_req_i ? (idle_cnt_r == 2'h3) : (supply_select_i == 2'h0);

  // Switch closes to the chosen level while a card sits in the slot
  assign presence_pin_o = pin_high_i ? card_in_i : !card_in_i;
endmodule

// >>> verif/card_supply_timer_and_detect_tb.sv
// Self-checking bench for the card supply timer and presence detector
`timescale 1ns/1ps
module card_supply_timer_and_detect_tb;
  logic        clk, arst_n, wr, rd, tick_32k, tick_1k, supply_good, lines_idle;
  logic        deact_req, card_logic_powerdown, pin, pu_n, pd, inserted, irq, fail, card_in, pin_high;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [1:0]  sel;
  logic [3:0]  tcnt;
  int          mismatches, compares, c;

  // ==========================================================
  // Design, far side, clock and ticks
  card_supply_timer_and_detect DUT (.ref_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tick_32k_i(tick_32k),
    .tick_1k_i(tick_1k), .supply_good_i(supply_good), .lines_idle_i(lines_idle),
    .supply_select_o(sel), .deact_req_o(deact_req), .card_logic_powerdown_o(card_logic_powerdown),
    .presence_pin_i(pin), .pullup_enable_n_o(pu_n), .pulldown_enable_o(pd),
    .card_inserted_o(inserted), .irq_o(irq));
  card_far_side far (.ref_clk_i(clk), .arst_n_i(arst_n), .supply_select_i(sel),
    .deact_req_i(deact_req), .fail_i(fail), .card_in_i(card_in), .pin_high_i(pin_high),
    .supply_good_o(supply_good), .lines_idle_o(lines_idle), .presence_pin_o(pin));

  // Clock at 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Fast ticks: 32 kHz every 8 cycles, 1 kHz every 16
  always @(posedge clk)
  begin
    tcnt <= tcnt + 4'h1;
    tick_32k <= (tcnt[2:0] == 3'h7);
    tick_1k <= (tcnt == 4'hF);
  end

  // ==========================================================
  // Helpers
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_deact;
    c = 0;
    while (deact_req !== 1'b1 && c < 400)
    begin
      @(posedge clk);
      #1 c++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    bus_rd("timing reset", 16'hFE04, card_supply_pkg::RST_SUPPLY_TIMING);
    bus_rd("detect reset", 16'hFE05, 8'h00);
    chk("pulls reset", 8'h00, {6'h0, pu_n, pd});
    bus_wr(16'hFE00, 8'hFF);
    bus_rd("unmapped", 16'hFE00, 8'h00);
    bus_wr(16'hFE04, 8'hA5);
    bus_rd("timing rw", 16'hFE04, 8'hA5);
    bus_wr(16'hFE05, 8'h37);
    cyc(1);
    chk("pulls set", 8'h03, {6'h0, pu_n, pd});
    bus_rd("detect rw", 16'hFE05, 8'h06);
    bus_wr(16'hFE05, 8'h00);
  endtask

  task automatic t_supply_ok;
    bus_wr(16'hFE04, 8'h03);
    for (int code = 1; code < 4; code++)
    begin
      bus_wr(16'hFE10, {code[1:0], 6'h00});
      cyc(1);
      chk("select", {6'h0, code[1:0]}, {6'h0, sel});
      cyc(50);
      chk("active", {code[1:0], 6'h00}, {sel, 5'h0, deact_req});
      bus_wr(16'hFE10, 8'h00);
      wait_deact;
      chk("no off delay", 8'h01, {7'h0, c <= 4});
      cyc(10);
      chk("supply off", 8'h00, {6'h0, sel});
      bus_rd("deact done", 16'hFE11, 8'h02);
      bus_wr(16'hFE11, 8'h03);
    end
  endtask

  task automatic t_supply_fail;
    fail <= 1'b1;
    bus_wr(16'hFE04, 8'h06);
    bus_wr(16'hFE10, 8'hC0);
    wait_deact;
    chk("stable time", 8'h01, {7'h0, c >= 40 && c <= 54});
    cyc(10);
    chk("select cleared", 8'h00, {6'h0, sel});
    bus_rd("fail status", 16'hFE11, 8'h03);
    chk("irq masked", 8'h00, {7'h0, irq});
    bus_wr(16'hFE12, 8'h01);
    cyc(2);
    chk("irq on", 8'h01, {7'h0, irq});
    bus_wr(16'hFE11, 8'h01);
    cyc(2);
    chk("irq cleared", 8'h00, {7'h0, irq});
    bus_wr(16'hFE11, 8'h03);
    fail <= 1'b0;
  endtask

  task automatic t_off_delay;
    bus_wr(16'hFE04, 8'h43);
    bus_wr(16'hFE10, 8'h80);
    cyc(50);
    bus_wr(16'hFE10, 8'h00);
    wait_deact;
    chk("off delay", 8'h01, {7'h0, c >= 24 && c <= 38});
    cyc(10);
    // Long off delay, then a supply fault in the middle of it
    bus_wr(16'hFE04, 8'hF3);
    bus_wr(16'hFE10, 8'h80);
    cyc(50);
    bus_wr(16'hFE10, 8'h00);
    cyc(4);
    @(posedge clk);
    fail <= 1'b1;
    wait_deact;
    chk("fault deact", 8'h01, {7'h0, c <= 6});
    cyc(10);
    fail <= 1'b0;
    bus_wr(16'hFE11, 8'h03);
  endtask

  task automatic t_detect;
    bus_wr(16'hFE05, 8'h08);
    bus_wr(16'hFE05, 8'h48);
    card_in <= 1'b1;
    cyc(3);
    chk("present high", 8'h01, {7'h0, inserted});
    bus_rd("detect flag", 16'hFE05, 8'h49);
    bus_rd("card event", 16'hFE11, 8'h01);
    bus_wr(16'hFE05, 8'h40);
    cyc(2);
    chk("pol flip", 8'h00, {7'h0, inserted});
    card_in <= 1'b0;
    cyc(3);
    chk("present low", 8'h01, {7'h0, inserted});
    bus_wr(16'hFE05, 8'h00);
    cyc(2);
    chk("disabled", 8'h00, {7'h0, inserted});
    bus_wr(16'hFE05, 8'h88);
    bus_wr(16'hFE05, 8'hC8);
    card_in <= 1'b1;
    // At most 63 slow ticks fit in 1000 cycles, 64 always fit in 1040
    cyc(1000);
    chk("debounce wait", 8'h00, {7'h0, inserted});
    cyc(40);
    chk("debounced", 8'h01, {7'h0, inserted});
    card_in <= 1'b0;
    cyc(2);
    chk("removal", 8'h00, {7'h0, inserted});
    bus_wr(16'hFE10, 8'h01);
    card_in <= 1'b1;
    cyc(3);
    chk("powerdown", 8'h03, {6'h0, card_logic_powerdown, inserted});
    bus_wr(16'hFE10, 8'h00);
    bus_wr(16'hFE05, 8'h00);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {arst_n, wr, rd, fail, card_in, pin_high, tick_32k, tick_1k} = 8'h04;
    addr = 16'h0000;
    wdata = 8'h00;
    tcnt = 4'h0;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_supply_ok;
    t_supply_fail;
    t_off_delay;
    t_detect;
    end_of_test;
  end

  // Cut a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
